// ===== hw/sfmhr_fifo.sv
`timescale 1ns/1ps
module sfmhr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
)
(
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic i_clear,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic push;
  logic pop;
  logic full;
  logic empty;

  assign full = (wr_ptr[AW] != rd_ptr[AW]) &&
    (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign empty = (wr_ptr == rd_ptr);
  assign push = i_valid && !full;
  assign pop = i_ready && !empty;
  assign o_ready = !full;
  assign o_valid = !empty;
  assign o_data = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge i_ref_clk)
  begin
    if (push)
    begin
      mem[wr_ptr[AW-1:0]] <= i_data;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else if (i_clear)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop)
      begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule // sfmhr_fifo

// ===== hw/sfmhr_pkg.sv
package sfmhr_pkg;

  // ==========================================================================
  // Commands
  // ==========================================================================
  localparam logic [7:0] CMD_ENTER_QUAD_INSTR = 8'h38;
  localparam logic [7:0] CMD_EXIT_QUAD_INSTR = 8'hFF;
  localparam logic [7:0] CMD_RESET_ENABLE = 8'h66;
  localparam logic [7:0] CMD_RESET = 8'h99;
  localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] CMD_VOL_WRITE_ENABLE = 8'h50;
  localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] CMD_WRITE_STATUS = 8'h01;
  localparam logic [7:0] CMD_READ_STATUS_ONE = 8'h05;
  localparam logic [7:0] CMD_READ_STATUS_TWO = 8'h35;
  localparam logic [7:0] CMD_READ_STATUS_THREE = 8'h15;
  localparam logic [7:0] CMD_DTR_READ = 8'h0D;

  // ==========================================================================
  // Status register one, two and three field positions
  // ==========================================================================
  localparam int SR1_BUSY_POS = 0;
  localparam int SR1_WEL_POS = 1;
  localparam int SR1_BP_LSB = 2;
  localparam int SR1_TB_POS = 5;
  localparam int SR1_SEC_POS = 6;
  localparam int SR1_STATUS_PROTECT_LO_POS = 7;
  localparam int SR2_STATUS_PROTECT_HI_POS = 0;
  localparam int SR2_QE_POS = 1;
  localparam int SR2_CMP_POS = 6;
  localparam int SR3_PAUSE_RESET_SELECT_POS = 7;

  // ==========================================================================
  // Reset values and volatile masks
  // ==========================================================================
  localparam logic [7:0] SR1_RESET = 8'h00;
  localparam logic [7:0] SR2_RESET = 8'h00;
  localparam logic [7:0] SR3_RESET = 8'h10;
  localparam logic [7:0] SR1_VOL_MASK = 8'hFC;
  localparam logic [7:0] SR2_VOL_MASK = 8'h43;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLK_PERIOD_NS = 50;
  localparam int SW_RESET_TIME_NS = 10000;
  localparam int SW_RESET_CYCLES = SW_RESET_TIME_NS / CLK_PERIOD_NS;
  localparam int HW_RESET_PULSE_TIME_NS = 1000;
  localparam int HW_RESET_PULSE_CYCLES =
    (HW_RESET_PULSE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STATUS_WRITE_TIME_NS = 2000;
  localparam int STATUS_WRITE_CYCLES = STATUS_WRITE_TIME_NS / CLK_PERIOD_NS;
  localparam logic [8:0] CNT_ZERO = 9'h000;

  // ==========================================================================
  // Buffer
  // ==========================================================================
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 16;

  typedef enum logic [4:0] {
    SFMHR_ST_IDLE = 5'b00001,
    SFMHR_ST_INSTR = 5'b00010,
    SFMHR_ST_DATA_IN = 5'b00100,
    SFMHR_ST_DATA_OUT = 5'b01000,
    SFMHR_ST_IGNORE = 5'b10000
  } sfmhr_state_t;

endpackage

// ===== hw/sfmhr_top.sv
`timescale 1ns/1ps
module sfmhr_top
(
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_data_line_0,
  output logic o_data_line_0,
  output logic o_data_line_0_oe,
  input wire logic i_data_line_1,
  output logic o_data_line_1,
  output logic o_data_line_1_oe,
  input wire logic i_data_line_2,
  output logic o_data_line_2,
  output logic o_data_line_2_oe,
  input wire logic i_data_line_3,
  output logic o_data_line_3,
  output logic o_data_line_3_oe,
  output logic o_quad_instr_mode,
  output logic o_paused,
  output logic o_busy,
  output logic [7:0] o_status_register_one,
  output logic o_block_protect_active,
  output logic o_rx_valid,
  output logic [7:0] o_rx_data,
  input wire logic i_rx_ready
);
  // ==========================================================================
  // Input synchronisers
  // ==========================================================================
  logic [5:0] sync1;
  logic [5:0] sync2;
  logic sclk_d;
  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      sync1 <= 6'h01;
      sync2 <= 6'h01;
      sclk_d <= 1'b0;
    end
    else
    begin
      sync1 <= {i_data_line_3, i_data_line_2, i_data_line_1, i_data_line_0,
        i_sclk, i_cs_n};
      sync2 <= sync1;
      sclk_d <= sync2[1];
    end
  end
  logic cs_n;
  logic sclk;
  logic [3:0] din;
  assign cs_n = sync2[0];
  assign sclk = sync2[1];
  assign din = sync2[5:2];
  logic sclk_rise;
  logic sclk_fall;
  assign sclk_rise = sclk && !sclk_d;
  assign sclk_fall = !sclk && sclk_d;

  // ==========================================================================
  // Status bits
  // ==========================================================================
  logic [7:0] sr1_nv;
  logic [7:0] sr2_nv;
  logic [7:0] sr3;
  logic [7:0] sr1_vol;
  logic [7:0] sr2_vol;
  logic write_enable_latch;
  logic vol_wel;
  logic quad_en;
  logic hold_sel;
  assign quad_en = sr2_vol[sfmhr_pkg::SR2_QE_POS];
  assign hold_sel = !quad_en && !sr3[sfmhr_pkg::SR3_PAUSE_RESET_SELECT_POS];

  // ==========================================================================
  // Hardware reset pin
  // ==========================================================================
  logic [8:0] hw_cnt;
  logic hw_pin_rst;
  logic reset_pin_low;
  assign reset_pin_low = !quad_en && sr3[sfmhr_pkg::SR3_PAUSE_RESET_SELECT_POS] && !din[3];
  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      hw_cnt <= sfmhr_pkg::CNT_ZERO;
    end
    else if (reset_pin_low)
    begin
      if (hw_cnt != 9'(sfmhr_pkg::HW_RESET_PULSE_CYCLES))
      begin
        hw_cnt <= hw_cnt + 9'h001;
      end
    end
    else
    begin
      hw_cnt <= sfmhr_pkg::CNT_ZERO;
    end
  end
  assign hw_pin_rst = reset_pin_low &&
    (hw_cnt == 9'(sfmhr_pkg::HW_RESET_PULSE_CYCLES) - 9'h001);

  // ==========================================================================
  // Pause
  // ==========================================================================
  logic paused;
  logic quad_xfer;
  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      paused <= 1'b0;
    end
    else if (cs_n || !hold_sel || quad_xfer)
    begin
      paused <= 1'b0;
    end
    else if (!sclk || sclk_fall)
    begin
      paused <= !din[3];
    end
  end

  // ==========================================================================
  // Protocol engine
  // ==========================================================================
  sfmhr_pkg::sfmhr_state_t state;
  logic quad_instr;
  logic reset_armed;
  logic [8:0] busy_cnt;
  logic [7:0] shreg;
  logic [3:0] bitcnt;
  logic [7:0] cmd;
  logic [7:0] txreg;
  logic dtr;
  logic wr_sr2;
  logic nv_pending;
  logic ren;
  logic fifo_ready;
  logic busy;
  logic step;
  logic [3:0] width;
  assign busy = busy_cnt != sfmhr_pkg::CNT_ZERO;
  assign step = !paused && (sclk_rise ||
    (dtr && sclk_fall && state == sfmhr_pkg::SFMHR_ST_DATA_IN));
  assign width = (quad_instr || quad_xfer) ? 4'h4 : 4'h1;
  assign quad_xfer = quad_instr;

  function automatic logic [7:0] shift_in(input logic [7:0] s,
    input logic [3:0] d, input logic [3:0] w);
    begin
      shift_in = (w == 4'h4) ? {s[3:0], d} : {s[6:0], d[0]};
    end
  endfunction

  function automatic logic nv_write_ok(input logic status_protect_lo, input logic status_protect_hi,
    input logic en, input logic qe, input logic wp);
    begin
      nv_write_ok = en && !status_protect_hi && (!status_protect_lo || qe || wp);
    end
  endfunction

  logic [7:0] next_byte;
  assign next_byte = shift_in(shreg, din, width);
  logic byte_done;
  assign byte_done = step && (bitcnt + width == 4'h8);

  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      state <= sfmhr_pkg::SFMHR_ST_IDLE;
      quad_instr <= 1'b0;
      reset_armed <= 1'b0;
      busy_cnt <= sfmhr_pkg::CNT_ZERO;
      shreg <= 8'h00;
      bitcnt <= 4'h0;
      cmd <= 8'h00;
      dtr <= 1'b0;
      wr_sr2 <= 1'b0;
      nv_pending <= 1'b0;
      write_enable_latch <= 1'b0;
      vol_wel <= 1'b0;
      sr1_nv <= sfmhr_pkg::SR1_RESET;
      sr2_nv <= sfmhr_pkg::SR2_RESET;
      sr3 <= sfmhr_pkg::SR3_RESET;
      sr1_vol <= sfmhr_pkg::SR1_RESET;
      sr2_vol <= sfmhr_pkg::SR2_RESET;
    end
    else if (hw_pin_rst)
    begin
      state <= sfmhr_pkg::SFMHR_ST_IDLE;
      quad_instr <= 1'b0;
      reset_armed <= 1'b0;
      busy_cnt <= sfmhr_pkg::CNT_ZERO;
      nv_pending <= 1'b0;
      write_enable_latch <= 1'b0;
      vol_wel <= 1'b0;
      sr1_vol <= sr1_nv & sfmhr_pkg::SR1_VOL_MASK;
      sr2_vol <= sr2_nv & sfmhr_pkg::SR2_VOL_MASK;
    end
    else if (busy)
    begin
      busy_cnt <= busy_cnt - 9'h001;
      if (busy_cnt == 9'h001)
      begin
        write_enable_latch <= 1'b0;
      end
      state <= sfmhr_pkg::SFMHR_ST_IGNORE;
    end
    else if (cs_n || reset_pin_low)
    begin
      state <= sfmhr_pkg::SFMHR_ST_IDLE;
      dtr <= 1'b0;
      // The write cycle starts only at frame end so both bytes are taken.
      if (nv_pending && cs_n)
      begin
        busy_cnt <= 9'(sfmhr_pkg::STATUS_WRITE_CYCLES);
        nv_pending <= 1'b0;
      end
    end
    else
    begin
      case (state)
        sfmhr_pkg::SFMHR_ST_IDLE:
        begin
          state <= sfmhr_pkg::SFMHR_ST_INSTR;
          bitcnt <= 4'h0;
        end
        sfmhr_pkg::SFMHR_ST_INSTR:
        begin
          if (step)
          begin
            shreg <= next_byte;
            bitcnt <= bitcnt + width;
          end
          if (byte_done)
          begin
            cmd <= next_byte;
            bitcnt <= 4'h0;
            state <= sfmhr_pkg::SFMHR_ST_IGNORE;
            if (reset_armed && next_byte == sfmhr_pkg::CMD_RESET)
            begin
              quad_instr <= 1'b0;
              write_enable_latch <= 1'b0;
              vol_wel <= 1'b0;
              sr1_vol <= sr1_nv & sfmhr_pkg::SR1_VOL_MASK;
              sr2_vol <= sr2_nv & sfmhr_pkg::SR2_VOL_MASK;
              busy_cnt <= 9'(sfmhr_pkg::SW_RESET_CYCLES);
            end
            reset_armed <= next_byte == sfmhr_pkg::CMD_RESET_ENABLE;
            case (next_byte)
              sfmhr_pkg::CMD_ENTER_QUAD_INSTR:
              begin
                if (quad_en)
                begin
                  quad_instr <= 1'b1;
                end
              end
              sfmhr_pkg::CMD_EXIT_QUAD_INSTR:
              begin
                quad_instr <= 1'b0;
              end
              sfmhr_pkg::CMD_WRITE_ENABLE:
              begin
                write_enable_latch <= 1'b1;
                vol_wel <= 1'b0;
              end
              sfmhr_pkg::CMD_VOL_WRITE_ENABLE:
              begin
                vol_wel <= 1'b1;
              end
              sfmhr_pkg::CMD_WRITE_DISABLE:
              begin
                write_enable_latch <= 1'b0;
                vol_wel <= 1'b0;
              end
              sfmhr_pkg::CMD_WRITE_STATUS:
              begin
                wr_sr2 <= 1'b0;
                state <= sfmhr_pkg::SFMHR_ST_DATA_IN;
              end
              sfmhr_pkg::CMD_DTR_READ:
              begin
                dtr <= 1'b1;
                state <= sfmhr_pkg::SFMHR_ST_DATA_IN;
              end
              sfmhr_pkg::CMD_READ_STATUS_ONE,
              sfmhr_pkg::CMD_READ_STATUS_TWO,
              sfmhr_pkg::CMD_READ_STATUS_THREE:
              begin
                state <= sfmhr_pkg::SFMHR_ST_DATA_OUT;
              end
              default:
              begin
              end
            endcase
          end
        end
        sfmhr_pkg::SFMHR_ST_DATA_IN:
        begin
          if (step)
          begin
            shreg <= next_byte;
            bitcnt <= bitcnt + width;
          end
          if (byte_done && cmd == sfmhr_pkg::CMD_WRITE_STATUS)
          begin
            bitcnt <= 4'h0;
            wr_sr2 <= 1'b1;
            if (vol_wel)
            begin
              if (!wr_sr2)
              begin
                sr1_vol <= next_byte & sfmhr_pkg::SR1_VOL_MASK;
              end
              else
              begin
                sr2_vol <= next_byte & sfmhr_pkg::SR2_VOL_MASK;
                vol_wel <= 1'b0;
              end
            end
            else if (nv_write_ok(sr1_nv[sfmhr_pkg::SR1_STATUS_PROTECT_LO_POS],
              sr2_nv[sfmhr_pkg::SR2_STATUS_PROTECT_HI_POS], write_enable_latch, quad_en, din[2]))
            begin
              if (!wr_sr2)
              begin
                sr1_nv <= next_byte & sfmhr_pkg::SR1_VOL_MASK;
                sr1_vol <= next_byte & sfmhr_pkg::SR1_VOL_MASK;
                nv_pending <= 1'b1;
              end
              else
              begin
                sr2_nv <= next_byte & sfmhr_pkg::SR2_VOL_MASK;
                sr2_vol <= next_byte & sfmhr_pkg::SR2_VOL_MASK;
                nv_pending <= 1'b1;
              end
            end
          end
          else if (byte_done)
          begin
            bitcnt <= 4'h0;
          end
        end
        sfmhr_pkg::SFMHR_ST_DATA_OUT:
        begin
        end
        sfmhr_pkg::SFMHR_ST_IGNORE:
        begin
        end
        default:
        begin
          state <= sfmhr_pkg::SFMHR_ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Captured data buffer
  // ==========================================================================
  logic fifo_push;
  logic fifo_valid;
  logic [7:0] fifo_data;
  assign fifo_push = byte_done && state == sfmhr_pkg::SFMHR_ST_DATA_IN;
  sfmhr_fifo #(
    .WIDTH(sfmhr_pkg::FIFO_WIDTH),
    .DEPTH(sfmhr_pkg::FIFO_DEPTH)
  ) u_fifo (
    .i_ref_clk(i_ref_clk),
    .i_rstn(i_rstn),
    .i_clear(hw_pin_rst),
    .i_valid(fifo_push),
    .o_ready(fifo_ready),
    .i_data(next_byte),
    .o_valid(fifo_valid),
    .i_ready(ren),
    .o_data(fifo_data)
  );
  assign ren = i_rx_ready || !o_rx_valid;

  // ==========================================================================
  // Output drive
  // ==========================================================================
  logic [7:0] sr_sel;
  always_comb
  begin
    sr_sel = {sr1_vol[7:2], write_enable_latch, busy};
    if (cmd == sfmhr_pkg::CMD_READ_STATUS_TWO)
    begin
      sr_sel = sr2_vol;
    end
    else if (cmd == sfmhr_pkg::CMD_READ_STATUS_THREE)
    begin
      sr_sel = sr3;
    end
  end

  logic driving;
  assign driving = state == sfmhr_pkg::SFMHR_ST_DATA_OUT && !paused;
  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      txreg <= 8'h00;
      o_data_line_0 <= 1'b0;
      o_data_line_1 <= 1'b0;
      o_data_line_2 <= 1'b0;
      o_data_line_3 <= 1'b0;
      o_data_line_0_oe <= 1'b0;
      o_data_line_1_oe <= 1'b0;
      o_data_line_2_oe <= 1'b0;
      o_data_line_3_oe <= 1'b0;
      o_quad_instr_mode <= 1'b0;
      o_paused <= 1'b0;
      o_busy <= 1'b0;
      o_status_register_one <= sfmhr_pkg::SR1_RESET;
      o_block_protect_active <= 1'b0;
      o_rx_valid <= 1'b0;
      o_rx_data <= 8'h00;
    end
    else
    begin
      if (state != sfmhr_pkg::SFMHR_ST_DATA_OUT)
      begin
        txreg <= sr_sel;
      end
      else if (sclk_fall && !paused)
      begin
        if (quad_instr)
        begin
          {o_data_line_3, o_data_line_2, o_data_line_1, o_data_line_0} <=
            txreg[7:4];
          txreg <= {txreg[3:0], sr_sel[7:4]};
        end
        else
        begin
          o_data_line_1 <= txreg[7];
          txreg <= {txreg[6:0], txreg[7]};
        end
      end
      o_data_line_1_oe <= driving;
      o_data_line_0_oe <= driving && quad_instr;
      o_data_line_2_oe <= driving && quad_instr;
      o_data_line_3_oe <= driving && quad_instr;
      o_quad_instr_mode <= quad_instr;
      o_paused <= paused;
      o_busy <= busy;
      o_status_register_one <= {sr1_vol[7:2], write_enable_latch, busy};
      o_block_protect_active <= sr1_vol[4:2] != 3'h0;
      if (ren && fifo_valid)
      begin
        o_rx_valid <= 1'b1;
        o_rx_data <= fifo_data;
      end
      else if (i_rx_ready)
      begin
        o_rx_valid <= 1'b0;
      end
    end
  end
endmodule // sfmhr_top

// ===== verif/sfmhr_host_model.sv
`timescale 1ns/1ps
module sfmhr_host_model
(
  output logic o_sclk,
  output logic o_cs_n,
  output logic [3:0] o_line
);
  initial
  begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_line = 4'hC;
  end

  // Clock idles low between frames; data lines 0 and 1 flip level, lines 2 and 3 are held high.
  task automatic frame(input logic [23:0] d, input int nb, input logic q);
    int i;
    o_cs_n = 1'b0;
    for (i = 23; i > 23 - 8 * nb; i = i - (q ? 4 : 1))
    begin
      if (q)
        o_line = d[i -: 4];
      else
        o_line = {2'b11, ~o_line[1], d[i]};
      #200 o_sclk = 1'b1;
      #200 o_sclk = 1'b0;
    end
    #200 o_cs_n = 1'b1;
    o_line = {2'b11, ~o_line[1:0]};
    #400;
  endtask
endmodule // sfmhr_host_model

// ===== verif/sfmhr_top_properties.sv
`timescale 1ns/1ps
module sfmhr_top_properties
(
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic i_cs_n,
  input wire logic o_data_line_0_oe,
  input wire logic o_data_line_1_oe,
  input wire logic o_quad_instr_mode,
  input wire logic o_paused,
  input wire logic o_busy,
  input wire logic [7:0] o_status_register_one,
  input wire logic o_block_protect_active
);
  logic [8:0] busy_cnt;

  default clocking @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rstn);

  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      busy_cnt <= 9'h000;
    else if (o_busy)
      busy_cnt <= busy_cnt + 9'h001;
    else
      busy_cnt <= 9'h000;
  end

  chk_reset_clean: assert property (
    $rose(i_rstn) |-> o_status_register_one == 8'h00 && !o_quad_instr_mode)
    else $error("state not clean after reset");
  chk_bp_flag: assert property (
    $stable(o_status_register_one) |->
    o_block_protect_active == (o_status_register_one[4:2] != 3'h0))
    else $error("protect flag disagrees with field");
  chk_busy_bit: assert property (
    $stable(o_busy) |-> o_status_register_one[0] == o_busy)
    else $error("busy bit disagrees with busy");
  chk_busy_span: assert property (
    $fell(o_busy) |-> busy_cnt >= 9'h027 && busy_cnt <= 9'h0C9)
    else $error("busy period length wrong");
  chk_wel_after_op: assert property (
    $fell(o_busy) |-> ##[0:1] !o_status_register_one[1])
    else $error("write enable latch not cleared");
  chk_wel_no_busy: assert property (
    $rose(o_status_register_one[1]) |-> !$past(o_busy))
    else $error("command taken while busy");
  chk_pause_float: assert property (
    o_paused |-> !o_data_line_0_oe && !o_data_line_1_oe)
    else $error("output driven while paused");
  chk_pause_quad: assert property (
    o_paused |-> !o_quad_instr_mode)
    else $error("pause in four-wire mode");
  chk_pause_select: assert property (
    i_cs_n [*5] |-> !o_paused)
    else $error("pause while deselected");

  cover property ($rose(o_quad_instr_mode));
  cover property ($fell(o_busy));
  cover property ($rose(o_block_protect_active));
endmodule // sfmhr_top_properties

bind sfmhr_top sfmhr_top_properties sfmhr_top_properties_inst (
  .i_ref_clk, .i_rstn, .i_cs_n, .o_data_line_0_oe, .o_data_line_1_oe,
  .o_quad_instr_mode, .o_paused, .o_busy, .o_status_register_one,
  .o_block_protect_active
);

// ===== verif/sfmhr_top_tb.sv
`timescale 1ns/1ps
module sfmhr_top_tb;
  logic clk;
  logic rstn;
  logic sclk;
  logic cs_n;
  logic rx_ready;
  logic [3:0] hl;
  logic [3:0] dout;
  logic [3:0] doe;
  logic [3:0] ln;
  logic quad, paused, busy, bpa, rxv;
  logic [7:0] sr1, rxd;
  int n_errors = 0;
  int checked = 0;

  assign ln = (doe & dout) | (~doe & hl);

  sfmhr_top sfmhr_top_inst (
    .i_ref_clk(clk), .i_rstn(rstn), .i_sclk(sclk), .i_cs_n(cs_n),
    .i_data_line_0(ln[0]), .o_data_line_0(dout[0]),
    .o_data_line_0_oe(doe[0]), .i_data_line_1(ln[1]),
    .o_data_line_1(dout[1]), .o_data_line_1_oe(doe[1]),
    .i_data_line_2(ln[2]), .o_data_line_2(dout[2]),
    .o_data_line_2_oe(doe[2]), .i_data_line_3(ln[3]),
    .o_data_line_3(dout[3]), .o_data_line_3_oe(doe[3]),
    .o_quad_instr_mode(quad), .o_paused(paused), .o_busy(busy),
    .o_status_register_one(sr1), .o_block_protect_active(bpa),
    .o_rx_valid(rxv), .o_rx_data(rxd), .i_rx_ready(rx_ready)
  );

  sfmhr_host_model sfmhr_host_model_inst (
    .o_sclk(sclk), .o_cs_n(cs_n), .o_line(hl)
  );

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic tally_and_finish;
    if (n_errors == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic cmd(input logic [7:0] c, input logic q);
    sfmhr_host_model_inst.frame({c, 16'h0000}, 1, q);
  endtask

  task automatic wrsr(input logic [7:0] s1);
    sfmhr_host_model_inst.frame({8'h01, s1, 8'h02}, 3, 1'b0);
  endtask

  task automatic wait_idle;
    int i;
    for (i = 0; i < 400 && busy !== 1'b0; i++)
      #50;
  endtask

  task automatic pop(input logic [7:0] exp);
    check(rxd, exp);
    rx_ready = 1'b1;
    #50 rx_ready = 1'b0;
  endtask

  task automatic t_start;
    check(sr1, 8'h00);
    check({7'h00, quad}, 8'h00);
    wrsr(8'h1C);
    check({7'h00, busy}, 8'h00);
    check(sr1, 8'h00);
  endtask

  task automatic t_wel;
    cmd(8'h06, 1'b0);
    check(sr1, 8'h02);
    cmd(8'h38, 1'b0);
    check({7'h00, quad}, 8'h00);
  endtask

  task automatic t_status;
    wrsr(8'h1C);
    check({7'h00, busy}, 8'h01);
    wait_idle;
    check(sr1, 8'h1C);
    check({7'h00, bpa}, 8'h01);
    check({7'h00, rxv}, 8'h01);
    pop(8'h1C);
    pop(8'h02);
  endtask

  task automatic t_qpi;
    cmd(8'h38, 1'b0);
    check({7'h00, quad}, 8'h01);
    cmd(8'h06, 1'b1);
    check(sr1, 8'h1E);
    cmd(8'hFF, 1'b1);
    check({7'h00, quad}, 8'h00);
  endtask

  task automatic t_volatile;
    cmd(8'h50, 1'b0);
    wrsr(8'h00);
    wait_idle;
    check(sr1 & 8'hFC, 8'h00);
    check({7'h00, bpa}, 8'h00);
  endtask

  task automatic t_swreset;
    cmd(8'h38, 1'b0);
    cmd(8'h66, 1'b1);
    cmd(8'h99, 1'b1);
    check({7'h00, busy}, 8'h01);
    cmd(8'h06, 1'b0);
    wait_idle;
    check(sr1, 8'h1C);
    check({7'h00, quad}, 8'h00);
  endtask

  initial
  begin
    rstn = 1'b0;
    rx_ready = 1'b0;
    repeat (10) @(posedge clk);
    #1 rstn = 1'b1;
    #200;
    t_start;
    t_wel;
    t_status;
    t_qpi;
    t_volatile;
    t_swreset;
    tally_and_finish;
  end

  initial
  begin
    #1000000;
    n_errors++;
    tally_and_finish;
  end
endmodule // sfmhr_top_tb
